// >>> logic/vps_pkg.sv
// Constants, register map and types for the video port channel sequencer.
// Assumes a 125 MHz system clock and an APB master with 32-bit data.
package vps_pkg;
  localparam int NCH = 4;
  localparam int NCAP = 2;
  localparam int CW = 8;
  localparam int AW = 8;
  localparam int DW = 32;

  localparam logic [AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [AW-1:0] GLOBAL_OFS = 8'h10;
  localparam logic [AW-1:0] STATUS_OFS = 8'h14;

  // Fields of each channel_control_reg.
  localparam int B_RUN = 0;
  localparam int B_PIX = 1;
  localparam int B_MID = 2;
  localparam int B_RAW = 3;
  localparam int B_INTL = 4;
  localparam int B_TOP = 5;
  localparam int B_BOT = 6;
  localparam int B_FREE = 7;
  localparam logic [CW-1:0] CTRL_RST = 8'h00;

  // Global register: BT.656 shared-clock mode.
  localparam int G_BT656 = 0;
  localparam logic GLOBAL_RST = 1'b0;

  // Status register layout.
  localparam int ST_STORE = 0;
  localparam int ST_HELD = 4;
  localparam int ST_PWR = 8;

  // Positions in the synchroniser bundle.
  localparam int SY_CLK = 0;
  localparam int SY_L5 = 4;
  localparam int SY_L11 = 8;
  localparam int SY_EAV1 = 12;
  localparam int SY_EAV7 = 16;
  localparam int SY_RAWV = 20;
  localparam int SY_OVF = 24;
  localparam int SY_LEN = 28;
  localparam int SY_TRC = 32;
  localparam int SY_FETCH = 36;
  localparam int SY_SUSP = 40;
  localparam int SY_PDA = 41;
  localparam int SY_PDB = 42;
  localparam int NSYNC = 43;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_ARMED = 4'h2,
    ST_RUN = 4'h4,
    ST_HOLD = 4'h8
  } vps_state_type;

  function automatic logic is_capture(input int ch);
    return ch < NCAP;
  endfunction
endpackage

// >>> logic/vps_sync.sv
// Two-stage synchroniser for a bundle of independent level signals.
// Assumes each bit is a level that stays stable for several clk periods.
`timescale 1ns/10ps
module vps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> logic/vps_top.sv
// Channel sequencing for a four-channel video port: two capture channels,
// two display channels, APB register slave and power/suspend interlocks.
// Assumes video timing events arrive as levels held for a pixel clock period,
// sampled at the rising pixel clock edge found by the system clock.
//
// Operation
// - first vsync: line L11 interlaced, L5 progressive
// - raw mid-frame start captures at once
// - capture stores from first vsync after activation
// - interrupt at that vsync, before any data
// - top and bottom interrupts enabled by config
// - display outputs right after fetch, no dummy frame
// - activation mid-frame skips to next frame
// - power change accepted only with all channels off
// - suspend input high means processor halted
// - capture finishes frame, then stalls while suspended
// - software stop only, no hardware stop
// - display finishes frame, withholds interrupts when suspended
// - suspended display repeats frame, ignores register changes
// - suspended writes apply at first vsync after release
// - run bit clear stops at once, writes immediate
// - display pixel output gated by control bit
// - late pixel enable reports underflow until vsync
// - BT.656: input clock drives output, one capture
// - YC interrupt at EAV L1, L7 for bottom
// - error interrupt on overflow, length, code errors
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
module vps_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vps_pkg::AW-1:0] paddr,
  input wire logic [vps_pkg::DW-1:0] pwdata,
  output logic [vps_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [vps_pkg::NCH-1:0] vid_clk,
  input wire logic [vps_pkg::NCH-1:0] line_l5_edge,
  input wire logic [vps_pkg::NCH-1:0] line_l11_edge,
  input wire logic [vps_pkg::NCH-1:0] eav_l1,
  input wire logic [vps_pkg::NCH-1:0] eav_l7,
  input wire logic [vps_pkg::NCH-1:0] raw_vstart,
  input wire logic [vps_pkg::NCH-1:0] buf_overflow,
  input wire logic [vps_pkg::NCH-1:0] line_len_err,
  input wire logic [vps_pkg::NCH-1:0] trc_bit_err,
  input wire logic [vps_pkg::NCH-1:0] fetch_valid,
  input wire logic emu_suspend,
  input wire logic pd_req_a,
  input wire logic pd_req_b,
  output logic [vps_pkg::NCH-1:0] vert_irq,
  output logic port_error_irq,
  output logic [vps_pkg::NCH-1:0] store_en,
  output logic [vps_pkg::NCH-1:0] pix_out_en,
  output logic [vps_pkg::NCH-1:0] frame_reread,
  output logic pwr_down
);
  import vps_pkg::*;

  logic [CW-1:0] cfg_q [NCH];
  logic bt656_q;
  logic pwr_down_q;
  logic [DW-1:0] prdata_q;
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sy;
  logic [NCH-1:0] err_vec;
  logic [NCH-1:0] hold_vec;
  logic [NCH-1:0] store_vec;
  logic [NCH-1:0] run_vec;

  // All video, suspend and power-request pins pass the two-flop synchroniser before any use.
  assign sync_in = {pd_req_b, pd_req_a, emu_suspend, fetch_valid, trc_bit_err,
    line_len_err, buf_overflow, raw_vstart, eav_l7, eav_l1, line_l11_edge,
    line_l5_edge, vid_clk};

  vps_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d(sync_in),
    .q(sy)
  );

  wire [NCH-1:0] s_clk = sy[SY_CLK +: NCH];
  wire [NCH-1:0] s_l5 = sy[SY_L5 +: NCH];
  wire [NCH-1:0] s_l11 = sy[SY_L11 +: NCH];
  wire [NCH-1:0] s_eav1 = sy[SY_EAV1 +: NCH];
  wire [NCH-1:0] s_eav7 = sy[SY_EAV7 +: NCH];
  wire [NCH-1:0] s_rawv = sy[SY_RAWV +: NCH];
  wire [NCH-1:0] s_ovf = sy[SY_OVF +: NCH];
  wire [NCH-1:0] s_len = sy[SY_LEN +: NCH];
  wire [NCH-1:0] s_trc = sy[SY_TRC +: NCH];
  wire [NCH-1:0] s_fetch = sy[SY_FETCH +: NCH];
  wire s_susp = sy[SY_SUSP];
  wire s_pda = sy[SY_PDA];
  wire s_pdb = sy[SY_PDB];

  // APB decode. The slave never inserts wait states.
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire word_ok = (paddr[1:0] == 2'h0);
  wire hit_ctrl = word_ok & (paddr >= CTRL_OFS) & (paddr < GLOBAL_OFS);
  wire hit_glb = word_ok & (paddr == GLOBAL_OFS);
  wire hit_st = word_ok & (paddr == STATUS_OFS);
  wire mapped = hit_ctrl | hit_glb | hit_st;
  wire [1:0] ctrl_idx = paddr[3:2];
  wire wr_en = apb_access & pwrite & mapped;
  wire [DW-1:0] st_word = {{(DW-ST_PWR-1){1'b0}}, pwr_down_q,
    hold_vec, store_vec};
  wire [DW-1:0] rd_word = hit_ctrl ? {{(DW-CW){1'b0}}, cfg_q[ctrl_idx]} :
    hit_glb ? {{(DW-1){1'b0}}, bt656_q} :
    hit_st ? st_word : '0;

  assign pready = 1'b1;
  assign pslverr = apb_access & ~mapped;
  assign prdata = prdata_q;
  assign pwr_down = pwr_down_q;
  assign port_error_irq = |err_vec;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prdata_q <= '0;
    end
    else if (apb_setup)
    begin
      prdata_q <= rd_word;
    end
  end

  // Control writes land at the access edge and act at once; on a held channel only the run bit does.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int n = 0; n < NCH; n++)
      begin
        cfg_q[n] <= CTRL_RST;
      end
      bt656_q <= GLOBAL_RST;
    end
    else if (wr_en & hit_ctrl)
    begin
      cfg_q[ctrl_idx] <= pwdata[CW-1:0];
    end
    else if (wr_en & hit_glb)
    begin
      bt656_q <= pwdata[G_BT656];
    end
  end

  // The power domains may only move while no channel runs; a split
  // request from the two domains is held off as well.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pwr_down_q <= 1'b0;
    end
    else if ((run_vec == '0) & (s_pda == s_pdb))
    begin
      pwr_down_q <= s_pda;
    end
  end

  genvar i;
  for (i = 0; i < NCH; i++)
  begin : g_ch
    vps_state_type state_q;
    vps_state_type state_d;
    logic [CW-1:0] act_q;
    logic frozen_q;
    logic ck_prev_q;
    logic unset_q;
    logic irq_q;
    logic err_q;
    logic store_q;
    logic pix_q;
    logic reread_q;

    localparam logic CAP = is_capture(i);
    localparam logic SPARE_CAP = (i == NCAP - 1);

    // In BT.656 the capture clock also times the display side, and the
    // second capture channel carries no data.
    wire run = cfg_q[i][B_RUN] & ~(bt656_q & SPARE_CAP);
    wire ck = (bt656_q & ~CAP) ? s_clk[0] : s_clk[i];
    wire pedge = ck & ~ck_prev_q;
    // While held the shadow copy rules; otherwise a write acts at once.
    wire [CW-1:0] mode = frozen_q ? act_q : cfg_q[i];
    wire raw = CAP & mode[B_RAW];
    wire intl = mode[B_INTL];
    wire vs_line = intl ? s_l11[i] : s_l5[i];
    wire fs = pedge & (raw ? s_rawv[i] : vs_line);
    // Free-run channels never see suspend.
    wire hold_req = s_susp & ~mode[B_FREE];
    wire top_ev = pedge & (raw ? s_rawv[i] : s_eav1[i]) & mode[B_TOP];
    wire bot_ev = pedge & ~raw & intl & s_eav7[i] & mode[B_BOT];
    wire in_run = (state_q == ST_RUN);
    wire in_hold = (state_q == ST_HOLD);
    wire first_irq = (state_q == ST_ARMED) & fs & mode[B_TOP];
    wire pix_rise = ~frozen_q & in_run & cfg_q[i][B_PIX] & ~act_q[B_PIX];
    wire err_ev = pedge & run &
      (s_ovf[i] | (CAP & (s_len[i] | s_trc[i])) | (unset_q & ~CAP));
    wire susp_exit = in_hold & fs & ~hold_req;

    always_comb
    begin
      state_d = state_q;
      case (state_q)
        ST_IDLE:
        begin
          if (run & CAP & ~(raw & mode[B_MID]))
          begin
            state_d = ST_ARMED;
          end
          else if (run)
          begin
            state_d = ST_RUN;
          end
        end
        ST_ARMED:
        begin
          // A frame already past its vsync is skipped whole.
          if (!run)
          begin
            state_d = ST_IDLE;
          end
          else if (fs)
          begin
            state_d = ST_RUN;
          end
        end
        ST_RUN:
        begin
          // Suspend only takes hold at the frame boundary; there is no
          // hard stop mid-frame.
          if (!run)
          begin
            state_d = ST_IDLE;
          end
          else if (fs & hold_req)
          begin
            state_d = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (!run)
          begin
            state_d = ST_IDLE;
          end
          else if (susp_exit)
          begin
            state_d = ST_RUN;
          end
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end

    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        state_q <= ST_IDLE;
        ck_prev_q <= 1'b0;
      end
      else
      begin
        state_q <= run ? state_d : ST_IDLE;
        ck_prev_q <= ck;
      end
    end

    // Settings written while held stay shadowed until the first vsync
    // after release, so the repeated frame is never disturbed.
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        frozen_q <= 1'b0;
        act_q <= CTRL_RST;
      end
      else
      begin
        if (state_d == ST_HOLD)
        begin
          frozen_q <= 1'b1;
        end
        else if (susp_exit | ~run)
        begin
          frozen_q <= 1'b0;
        end
        if (!frozen_q)
        begin
          act_q <= cfg_q[i];
        end
      end
    end

    // Turning pixels on mid-frame leaves the FIFO short until the next
    // vsync; that window is reported as an underflow error.
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        unset_q <= 1'b0;
      end
      else if (pix_rise & run)
      begin
        unset_q <= 1'b1;
      end
      else if (fs | ~run)
      begin
        unset_q <= 1'b0;
      end
    end

    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        irq_q <= 1'b0;
        err_q <= 1'b0;
        store_q <= 1'b0;
        pix_q <= 1'b0;
        reread_q <= 1'b0;
      end
      else
      begin
        irq_q <= run & (first_irq | (in_run & (top_ev | bot_ev)));
        err_q <= err_ev;
        store_q <= CAP & run & (state_d == ST_RUN);
        pix_q <= ~CAP & run & (in_run | in_hold) & s_fetch[i] & mode[B_PIX];
        reread_q <= ~CAP & run & in_hold;
      end
    end

    assign vert_irq[i] = irq_q;
    assign err_vec[i] = err_q;
    assign store_en[i] = store_q;
    assign store_vec[i] = store_q;
    assign pix_out_en[i] = pix_q;
    assign frame_reread[i] = reread_q;
    assign hold_vec[i] = in_hold;
    assign run_vec[i] = cfg_q[i][B_RUN];
  end
endmodule

// >>> test/vps_vsrc.sv
// Far-side model: video source and encoder pixel clocks with vsync and EAV levels.
// Assumes the bench calls pulse to place one event on one whole pixel period.
`timescale 1ns/10ps
module vps_vsrc (
  output logic [3:0] vid_clk,
  output logic [3:0] l5,
  output logic [3:0] l11,
  output logic [3:0] e1,
  output logic [3:0] e7,
  output logic [3:0] rv
);
  initial
  begin
    vid_clk = '0;
    {l5, l11, e1, e7, rv} = '0;
  end
  // One shared source clock for all channels; video pixel clocks never stop.
  always #32 vid_clk = ~vid_clk;
  // Kind 0 to 4 selects line 5 edge, line 11 edge, EAV line 1, EAV line 7, raw start.
  task automatic pulse(input int k, input logic [3:0] m);
    @(posedge vid_clk[0]);
    {l5, l11, e1, e7, rv} = {m, m, m, m, m} & (20'h0000F << (4 * (4 - k)));
    @(posedge vid_clk[0]);
    {l5, l11, e1, e7, rv} = '0;
  endtask
endmodule

// >>> test/vps_checker.sv
// Port checker for vps_top: reset state, pulse shapes, stop, suspend and power.
// Assumes one clk domain with a synchronous active-high reset.
`timescale 1ns/10ps
module vps_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vps_pkg::AW-1:0] paddr,
  input wire logic [vps_pkg::DW-1:0] pwdata,
  input wire logic pd_req_a,
  input wire logic pd_req_b,
  input wire logic [vps_pkg::NCH-1:0] vert_irq,
  input wire logic port_error_irq,
  input wire logic [vps_pkg::NCH-1:0] store_en,
  input wire logic [vps_pkg::NCH-1:0] pix_out_en,
  input wire logic [vps_pkg::NCH-1:0] frame_reread,
  input wire logic pwr_down
);
  import vps_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic wr0 = psel && penable && pwrite && paddr == CTRL_OFS;
  property p_rst;
    $fell(reset) |-> store_en == '0 && pix_out_en == '0 && !pwr_down;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  property p_side;
    store_en[3:2] == '0 && pix_out_en[1:0] == '0 && frame_reread[1:0] == '0;
  endproperty
  a_side: assert property (p_side) else $error("output on wrong channel kind");
  property p_irq;
    vert_irq[0] |=> !vert_irq[0];
  endproperty
  a_irq: assert property (p_irq) else $error("frame pulse too long");
  property p_hold;
    frame_reread[2] |-> !vert_irq[2];
  endproperty
  a_hold: assert property (p_hold) else $error("pulse while repeating frame");
  property p_stop;
    wr0 && !pwdata[B_RUN] |-> ##[1:3] !store_en[0];
  endproperty
  a_stop: assert property (p_stop) else $error("store did not stop");
  property p_mid;
    wr0 && pwdata[3:0] == 4'hD |-> ##[1:3] store_en[0];
  endproperty
  a_mid: assert property (p_mid) else $error("raw start not at once");
  property p_pwr;
    $changed(pwr_down) |-> pwr_down == pd_req_a && pd_req_a == pd_req_b;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power change not requested");
  property p_err;
    port_error_irq |=> !port_error_irq;
  endproperty
  a_err: assert property (p_err) else $error("error pulse too long");
endmodule
bind vps_top vps_checker i_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pd_req_a(pd_req_a), .pd_req_b(pd_req_b),
  .vert_irq(vert_irq), .port_error_irq(port_error_irq), .store_en(store_en),
  .pix_out_en(pix_out_en), .frame_reread(frame_reread), .pwr_down(pwr_down));

// >>> test/video_port_channel_sequencing_tb.sv
// Self-checking bench for vps_top with an APB master and the video far-side model.
// Assumes a 125 MHz clk, 64 ns pixel clocks and the package register map.
`timescale 1ns/10ps
module video_port_channel_sequencing_tb;
  import vps_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, emu = 0, pd_a = 0, pd_b = 0;
  logic pready, pslverr, er, pwr_down, port_error_irq;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0, prdata, rd;
  logic [NCH-1:0] vid_clk, l5, l11, e1, e7, rv, vert_irq, store_en, pix_out_en, frame_reread;
  logic [NCH-1:0] ovf = '0, fetch = '0, lenr = '0, trce = '0;
  int n_errors = 0, cmp_count = 0, cyc = 0, nerr = 0, b, i;
  int nirq [NCH] = '{default: 0};
  always #4 clk = ~clk;
  vps_top i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vid_clk(vid_clk), .line_l5_edge(l5), .line_l11_edge(l11), .eav_l1(e1), .eav_l7(e7),
    .raw_vstart(rv), .buf_overflow(ovf), .line_len_err(lenr), .trc_bit_err(trce),
    .fetch_valid(fetch), .emu_suspend(emu), .pd_req_a(pd_a), .pd_req_b(pd_b),
    .vert_irq(vert_irq), .port_error_irq(port_error_irq), .store_en(store_en),
    .pix_out_en(pix_out_en), .frame_reread(frame_reread), .pwr_down(pwr_down));
  vps_vsrc i_src (.vid_clk(vid_clk), .l5(l5), .l11(l11), .e1(e1), .e7(e7), .rv(rv));
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    nerr += port_error_irq;
    for (int c = 0; c < NCH; c++)
      nirq[c] += vert_irq[c];
    if (cyc == 30000)
    begin
      n_errors++;
      close_out();
    end
  end
  function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
    return v & 32'h000000FF;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Counts frame pulses of channel c over one event and compares with n.
  task automatic ev(input int k, input logic [3:0] m, input int c, input int n);
    b = nirq[c];
    i_src.pulse(k, m);
    repeat (4) @(posedge clk);
    chk(nirq[c] - b, n);
  endtask
  initial
  begin
    void'($urandom(32'h732E1B02));
    repeat (2) @(posedge clk);
    reset <= 0;
    for (i = 0; i < 6; i++)
    begin
      apb(0, 8'(4 * i), '0);
      chk(rd, 0);
    end
    apb(0, 8'h20, '0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, 8'h02, 32'h000000FF);
    chk(er, 1);
    for (i = 0; i < NCH; i++)
    begin
      b = $urandom & 32'hFFFFFFFE;
      apb(1, 8'(4 * i), b);
      apb(0, 8'(4 * i), '0);
      chk(rd, ctrl_exp(b));
    end
    apb(1, CTRL_OFS, 32'h21);
    repeat (20) @(posedge clk);
    chk(store_en[0], 0);
    ev(1, 4'h1, 0, 0);
    ev(0, 4'h1, 0, 1);
    chk(store_en[0], 1);
    apb(1, 8'h04, 32'h31);
    ev(0, 4'h2, 1, 0);
    ev(1, 4'h2, 1, 1);
    emu <= 1;
    ev(0, 4'h1, 0, 0);
    chk(store_en[0], 0);
    apb(0, STATUS_OFS, '0);
    chk(rd[7:4], 4'h1);
    apb(1, CTRL_OFS, 32'h01);
    emu <= 0;
    i_src.pulse(0, 4'h1);
    repeat (4) @(posedge clk);
    chk(store_en[0], 1);
    ev(0, 4'h1, 0, 0);
    apb(1, CTRL_OFS, '0);
    repeat (3) @(posedge clk);
    chk(store_en[0], 0);
    apb(1, 8'h04, 32'hB1);
    emu <= 1;
    ev(1, 4'h2, 1, 0);
    ev(2, 4'h2, 1, 1);
    emu <= 0;
    ev(2, 4'h2, 1, 1);
    ev(3, 4'h2, 1, 0);
    apb(1, 8'h04, 32'h51);
    ev(3, 4'h2, 1, 1);
    ev(2, 4'h2, 1, 0);
    apb(1, CTRL_OFS, 32'h0D);
    repeat (3) @(posedge clk);
    chk(store_en[0], 1);
    fetch <= 4'hC;
    apb(1, 8'h08, 32'h21);
    repeat (3) @(posedge clk);
    chk(pix_out_en[2], 0);
    b = nerr;
    apb(1, 8'h08, 32'h23);
    repeat (3) @(posedge clk);
    chk(pix_out_en[2], 1);
    ev(0, 4'h4, 2, 0);
    chk(nerr > b, 1);
    b = nerr;
    repeat (30) @(posedge clk);
    chk(nerr - b, 0);
    emu <= 1;
    ev(0, 4'h4, 2, 0);
    ev(2, 4'h4, 2, 0);
    chk({frame_reread[2], pix_out_en[2]}, 2'b11);
    emu <= 0;
    ev(0, 4'h4, 2, 0);
    ev(2, 4'h4, 2, 1);
    apb(1, GLOBAL_OFS, 32'h01);
    apb(1, 8'h04, 32'h21);
    ev(0, 4'h2, 1, 0);
    pd_a <= 1;
    pd_b <= 1;
    repeat (8) @(posedge clk);
    chk(pwr_down, 0);
    for (i = 0; i < 5; i++)
      apb(1, 8'(4 * i), '0);
    repeat (8) @(posedge clk);
    chk(pwr_down, 1);
    pd_a <= 0;
    pd_b <= 0;
    repeat (8) @(posedge clk);
    chk(pwr_down, 0);
    for (i = 0; i < NCH; i++)
      apb(1, 8'(4 * i), 32'h01);
    for (i = 0; i < 6; i++)
    begin
      b = nerr;
      case (i % 3)
        0: ovf <= 4'h1 << ($urandom % NCH);
        1: lenr <= 4'h1 << ($urandom % NCAP);
        default: trce <= 4'h1 << ($urandom % NCAP);
      endcase
      repeat (16) @(posedge clk);
      {ovf, lenr, trce} <= '0;
      repeat (8) @(posedge clk);
      chk(nerr > b, 1);
    end
    close_out();
  end
endmodule
